// ### core/boot_select_pkg.sv
// Constants, field layouts and carrier types for the dual partition boot selector.
// Assumes a single 20 MHz clock and an Avalon-MM register slave with 32-bit data.
package boot_select_pkg;

  // Register byte offsets on the Avalon-MM slave
  localparam logic [4:0] MODE_CFG_OFFSET = 5'h00;  // partition_mode_config
  localparam logic [4:0] SEQ0_OFFSET = 5'h04;  // boot_sequence_word of partition 0
  localparam logic [4:0] SEQ1_OFFSET = 5'h08;  // boot_sequence_word of partition 1
  localparam logic [4:0] STATUS_OFFSET = 5'h0c;  // Selection status
  localparam logic [4:0] WR_CTRL_OFFSET = 5'h10;  // Partition write enables

  // Partition mode field, bits 1..0 of the mode word
  localparam int MODE_FIELD_LSB = 0;
  localparam logic [1:0] MODE_SINGLE = 2'h3;
  localparam logic [1:0] MODE_DUAL = 2'h2;
  localparam logic [1:0] MODE_PROT_DUAL = 2'h1;
  localparam logic [1:0] MODE_RESERVED = 2'h0;
  localparam logic [13:0] MODE_UNIMPL_ONES = 14'h3fff;  // Bits 15..2 read as one

  // Sequence word layout
  localparam int BOOT_NUM_LSB = 0;
  localparam int INV_NUM_LSB = 12;

  // Erased program-once values
  localparam logic [15:0] MODE_ERASED = 16'hffff;
  localparam logic [23:0] SEQ_ERASED = 24'hffffff;

  // Status register bit positions
  localparam int ST_READY = 0;
  localparam int ST_ACTIVE = 1;
  localparam int ST_DUAL = 2;
  localparam int ST_PROT = 3;
  localparam int ST_VALID0 = 4;
  localparam int ST_VALID1 = 5;
  localparam int ST_BLOCKED = 6;

  // Write control bit positions
  localparam int WR_EN0 = 0;
  localparam int WR_EN1 = 1;

  // Edges after reset release before the synchronised words are trusted
  localparam logic [1:0] LOAD_WAIT = 2'h2;

  // Boot number and its stored inverse
  typedef struct packed {
    logic [11:0] inv_num;
    logic [11:0] boot_num;
  } seq_word_t;

  // All configuration words travel together
  typedef struct packed {
    logic [15:0] mode;
    seq_word_t seq0;
    seq_word_t seq1;
  } cfg_words_t;

endpackage

// ### core/dual_partition_boot_select.sv
// Dual partition boot selector: captures the program-once configuration words
// after reset, picks the active partition, gates partition writes, and serves
// the words and status over an Avalon-MM slave with waitrequest.
// Assumes the configuration words arrive as static levels from the
// nonvolatile array, outside this clock domain.
//
// Our own choices: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps

module dual_partition_boot_select (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire boot_select_pkg::cfg_words_t cfg_words_pin,  // From nonvolatile array
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic cfg_ready,
  output logic active_part,
  output logic dual_mode,
  output logic part0_wr_en,
  output logic part1_wr_en
);

  // Load sequencing states
  typedef enum logic [1:0] {LOAD_SYNC, LOAD_CAPTURE, LOAD_DONE} load_state_t;

  boot_select_pkg::cfg_words_t sync1_q;  // First synchroniser stage only
  boot_select_pkg::cfg_words_t sync2_q;  // Second stage, safe to read
  boot_select_pkg::cfg_words_t cfg_q;  // Captured words, fixed until next reset
  load_state_t state_q;
  logic [1:0] wait_cnt_q;  // Settling edges after reset release
  logic ready_q;  // Words captured; gives cfg_ready straight from a flop
  logic active_q;  // Active partition index
  logic dual_q;  // Either dual mode
  logic prot_q;  // Protected dual mode
  logic valid0_q;
  logic valid1_q;
  logic blocked_q;  // Sticky: a refused partition 1 enable
  logic [1:0] wr_ctrl_q;  // Software write enables
  logic [31:0] rdata_q;
  logic wait_q;
  logic en0_q;
  logic en1_q;

  // Combinational decisions from the synchronised and captured words
  logic [1:0] mode_field;
  logic v0;
  logic v1;
  logic pick;
  logic ack;  // Access completes at this edge
  logic p1_locked;

  assign mode_field = cfg_q.mode[boot_select_pkg::MODE_FIELD_LSB +: 2];
  assign ack = (read | write) & ~wait_q;
  // A partition 1 enable is refused while protected and partition 1 is not active
  assign p1_locked = prot_q & ~active_q;

  // Inverse must match bit for bit, otherwise the word cannot vote
  always_comb begin
    v0 = (sync2_q.seq0.inv_num == ~sync2_q.seq0.boot_num);
    v1 = (sync2_q.seq1.inv_num == ~sync2_q.seq1.boot_num);
    // Lower unsigned number wins; a tie or no valid word falls to partition 0
    if (v0 && v1) begin
      pick = (sync2_q.seq1.boot_num < sync2_q.seq0.boot_num);
    end else if (v1) begin
      pick = 1'b1;
    end else begin
      pick = 1'b0;
    end
  end

  // Two-flop synchroniser; the words are static, so no word skew matters
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1_q <= {boot_select_pkg::MODE_ERASED, boot_select_pkg::SEQ_ERASED,
                  boot_select_pkg::SEQ_ERASED};
      sync2_q <= {boot_select_pkg::MODE_ERASED, boot_select_pkg::SEQ_ERASED,
                  boot_select_pkg::SEQ_ERASED};
    end else begin
      sync1_q <= cfg_words_pin;
      sync2_q <= sync1_q;
    end
  end

  // Load sequencer: settle, capture once, then hold until the next reset
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= LOAD_SYNC;
      wait_cnt_q <= 2'h0;
      ready_q <= 1'b0;
    end else begin
      case (state_q)
        LOAD_SYNC: begin
          if (wait_cnt_q == boot_select_pkg::LOAD_WAIT) begin
            state_q <= LOAD_CAPTURE;
          end else begin
            wait_cnt_q <= wait_cnt_q + 2'h1;
          end
        end
        LOAD_CAPTURE: begin
          state_q <= LOAD_DONE;
          // Rises together with LOAD_DONE, so it never runs ahead of the captured words
          ready_q <= 1'b1;
        end
        default: begin
          state_q <= LOAD_DONE;
        end
      endcase
    end
  end

  // Capture words and selection; never rewritten at run time
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_q <= {boot_select_pkg::MODE_ERASED, boot_select_pkg::SEQ_ERASED,
                boot_select_pkg::SEQ_ERASED};
      active_q <= 1'b0;
      dual_q <= 1'b0;
      prot_q <= 1'b0;
      valid0_q <= 1'b0;
      valid1_q <= 1'b0;
    end else if (state_q == LOAD_CAPTURE) begin
      cfg_q <= sync2_q;
      valid0_q <= v0;
      valid1_q <= v1;
      // Reserved code runs as single partition, the safe reading
      case (sync2_q.mode[boot_select_pkg::MODE_FIELD_LSB +: 2])
        boot_select_pkg::MODE_DUAL: begin
          dual_q <= 1'b1;
          prot_q <= 1'b0;
          active_q <= pick;
        end
        boot_select_pkg::MODE_PROT_DUAL: begin
          dual_q <= 1'b1;
          prot_q <= 1'b1;
          active_q <= pick;
        end
        default: begin
          dual_q <= 1'b0;
          prot_q <= 1'b0;
          active_q <= 1'b0;
        end
      endcase
    end
  end

  // Avalon handshake: waitrequest held high until LOAD_DONE, then one wait cycle and one cycle low per access
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wait_q <= 1'b1;
      rdata_q <= 32'h0;
    end else if ((read | write) && wait_q && state_q == LOAD_DONE) begin
      wait_q <= 1'b0;
      rdata_q <= 32'h0;
      if (address == boot_select_pkg::MODE_CFG_OFFSET) begin
        rdata_q[15:0] <= {boot_select_pkg::MODE_UNIMPL_ONES, mode_field};
      end else if (address == boot_select_pkg::SEQ0_OFFSET) begin
        rdata_q[23:0] <= cfg_q.seq0;
      end else if (address == boot_select_pkg::SEQ1_OFFSET) begin
        rdata_q[23:0] <= cfg_q.seq1;
      end else if (address == boot_select_pkg::STATUS_OFFSET) begin
        rdata_q[6:0] <= {blocked_q, valid1_q, valid0_q, prot_q, dual_q, active_q, 1'b1};
      end else if (address == boot_select_pkg::WR_CTRL_OFFSET) begin
        rdata_q[1:0] <= wr_ctrl_q;
      end else begin
        rdata_q <= 32'h0;  // Unmapped reads return zero
      end
    end else begin
      wait_q <= 1'b1;
    end
  end

  // Write control and the sticky refusal flag; a new refusal beats a clear
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ctrl_q <= 2'h0;
      blocked_q <= 1'b0;
    end else begin
      if (write && ack && byteenable[0] &&
          address == boot_select_pkg::WR_CTRL_OFFSET) begin
        wr_ctrl_q <= writedata[1:0];
        blocked_q <= (writedata[boot_select_pkg::WR_EN1] & p1_locked) | blocked_q;
      end else if (write && ack && byteenable[0] &&
                   address == boot_select_pkg::STATUS_OFFSET &&
                   writedata[boot_select_pkg::ST_BLOCKED]) begin
        blocked_q <= 1'b0;  // Write one to clear
      end
    end
  end

  // Enables to the flash controller; partition 1 gated in protected mode while partition 1 is not active
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      en0_q <= 1'b0;
      en1_q <= 1'b0;
    end else begin
      en0_q <= wr_ctrl_q[boot_select_pkg::WR_EN0] & (state_q == LOAD_DONE);
      en1_q <= wr_ctrl_q[boot_select_pkg::WR_EN1] & ~p1_locked & (state_q == LOAD_DONE);
    end
  end

  assign readdata = rdata_q;
  assign waitrequest = wait_q;
  assign cfg_ready = ready_q;
  assign active_part = active_q;
  assign dual_mode = dual_q;
  assign part0_wr_en = en0_q;
  assign part1_wr_en = en1_q;

  // Checks
  logic done;
  assign done = (state_q == LOAD_DONE);

  sequence s_mode_read;
    read && wait_q && done && address == boot_select_pkg::MODE_CFG_OFFSET;
  endsequence

  sequence s_p1_enable_refused;
    write && ack && byteenable[0] && address == boot_select_pkg::WR_CTRL_OFFSET &&
    writedata[boot_select_pkg::WR_EN1] && p1_locked;
  endsequence

  // Partition 1 enable requested while nothing locks it
  sequence s_p1_open;
    done && wr_ctrl_q[boot_select_pkg::WR_EN1] && !p1_locked;
  endsequence

  // Accepted write of one to the sticky refusal bit
  sequence s_blocked_clear;
    write && ack && byteenable[0] && address == boot_select_pkg::STATUS_OFFSET &&
    writedata[boot_select_pkg::ST_BLOCKED];
  endsequence

  a_mode_read_ones: assert property (@(posedge ref_clk) disable iff (!rst_b)
    s_mode_read |=> !wait_q && rdata_q[15:2] == boot_select_pkg::MODE_UNIMPL_ONES &&
    rdata_q[31:16] == 16'h0)
    else $error("mode word upper bits not read as one");

  a_seq_read_fields: assert property (@(posedge ref_clk) disable iff (!rst_b)
    read && wait_q && done && address == boot_select_pkg::SEQ1_OFFSET
    |=> rdata_q[23:12] == cfg_q.seq1.inv_num && rdata_q[11:0] == cfg_q.seq1.boot_num)
    else $error("sequence word fields misplaced");

  a_p1_write_block: assert property (@(posedge ref_clk) disable iff (!rst_b)
    prot_q && !active_q && $past(prot_q) && $past(!active_q) |-> !en1_q)
    else $error("inactive protected partition 1 enabled");

  a_refusal_sticky: assert property (@(posedge ref_clk) disable iff (!rst_b)
    s_p1_enable_refused |=> blocked_q ##1 blocked_q)
    else $error("refused enable not flagged");

  a_single_mode_sel: assert property (@(posedge ref_clk) disable iff (!rst_b)
    done && mode_field == boot_select_pkg::MODE_SINGLE |-> !dual_q && !active_q && !prot_q)
    else $error("single mode selected a second partition");

  a_prot_mode_sel: assert property (@(posedge ref_clk) disable iff (!rst_b)
    done && mode_field == boot_select_pkg::MODE_PROT_DUAL |-> dual_q && prot_q)
    else $error("protected mode not decoded");

  a_lower_num_wins: assert property (@(posedge ref_clk) disable iff (!rst_b)
    done && dual_q && valid0_q && valid1_q |->
    active_q == (cfg_q.seq1.boot_num < cfg_q.seq0.boot_num))
    else $error("higher boot number selected");

  a_invalid_no_vote: assert property (@(posedge ref_clk) disable iff (!rst_b)
    done && dual_q && valid0_q && !valid1_q |-> !active_q)
    else $error("partition with bad inverse selected");

  a_words_hold: assert property (@(posedge ref_clk) disable iff (!rst_b)
    done && $past(done) |-> $stable(cfg_q) && $stable(active_q))
    else $error("configuration changed at run time");

  a_wait_one_low: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $fell(wait_q) |=> wait_q)
    else $error("waitrequest low for more than one cycle");

  // The reserved code falls back to one partition rather than guessing a layout
  a_reserved_single: assert property (@(posedge ref_clk) disable iff (!rst_b)
    done && mode_field == boot_select_pkg::MODE_RESERVED |-> !dual_q && !prot_q && !active_q)
    else $error("reserved mode not run as single partition");

  // Plain dual mode must leave partition 1 writable
  a_dual_mode_sel: assert property (@(posedge ref_clk) disable iff (!rst_b)
    done && mode_field == boot_select_pkg::MODE_DUAL |-> dual_q && !prot_q)
    else $error("dual mode not decoded");

  // A lone valid partition 1 word must win over a corrupt partition 0 word
  a_valid1_only_wins: assert property (@(posedge ref_clk) disable iff (!rst_b)
    done && dual_q && !valid0_q && valid1_q |-> active_q)
    else $error("valid partition 1 not selected");

  // Gating must not swallow an enable that no protection forbids
  a_p1_enable_pass: assert property (@(posedge ref_clk) disable iff (!rst_b)
    s_p1_open |=> en1_q)
    else $error("unlocked partition 1 enable dropped");

  // Write one to clear must take effect at the next edge
  a_blocked_clear: assert property (@(posedge ref_clk) disable iff (!rst_b)
    s_blocked_clear |=> !blocked_q)
    else $error("refusal flag not cleared");

endmodule

// ### tb/dual_partition_boot_select_test.sv
// Self-checking bench for the dual partition boot selector.
// Assumes the core/ package and design compiled first; the bench drives every port itself.
`timescale 1ns/1ps

module dual_partition_boot_select_test;
  logic ref_clk = 1'h0;  // 20 MHz system clock
  logic rst_b = 1'h0;  // Held in reset at time zero
  boot_select_pkg::cfg_words_t cfg = '1;  // Static words from the array
  logic [4:0] address = 5'h00;
  logic read = 1'h0;
  logic write = 1'h0;
  logic [31:0] writedata = 32'h0;
  logic [3:0] byteenable = 4'h1;
  logic [31:0] readdata;
  logic waitrequest, cfg_ready, active_part, dual_mode, part0_wr_en, part1_wr_en;
  int bad_count = 0;  // Mismatches seen
  int checks = 0;  // Comparisons made
  int cycles = 0;  // Hang guard
  logic [31:0] rd;  // Last read data
  // Boot cases: mode field, sequence words, expected winner and validity
  // Cases 6..8: reserved code, equal numbers, only partition 1 valid
  logic [1:0] t_mode [9] = '{2'h3, 2'h2, 2'h2, 2'h2, 2'h1, 2'h1, 2'h0, 2'h2, 2'h2};
  logic [23:0] t_s0 [9] = '{24'hffffff, 24'hffa005, 24'h7ff800, 24'h7ff800, 24'hffd002,
                           24'hff6009, 24'hffffff, 24'hffe001, 24'h000001};
  logic [23:0] t_s1 [9] = '{24'hffffff, 24'hffc003, 24'h8007ff, 24'h000001, 24'hff6009,
                           24'hffb004, 24'hffc003, 24'hffe001, 24'hffb004};
  logic t_act [9] = '{1'h0, 1'h1, 1'h1, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0, 1'h1};
  logic [1:0] t_val [9] = '{2'h0, 2'h3, 2'h3, 2'h1, 2'h3, 2'h3, 2'h2, 2'h3, 2'h2};

  dual_partition_boot_select u_dut (
    .ref_clk(ref_clk), .rst_b(rst_b), .cfg_words_pin(cfg), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .cfg_ready(cfg_ready), .active_part(active_part),
    .dual_mode(dual_mode), .part0_wr_en(part0_wr_en), .part1_wr_en(part1_wr_en)
  );

  // Half period of 25 ns
  always #25 ref_clk = ~ref_clk;

  // Whole run needs about three hundred cycles, so five thousand means a hang
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      bad_count++;
      give_verdict();
    end
  end

  // Report and end the run
  task automatic give_verdict();
    $display("Checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Compare one value exactly; an unknown bit matches only an unknown bit
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One Avalon access; request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    address <= a;
    write <= wr;
    read <= ~wr;
    writedata <= d;
    byteenable <= be;
    // No fixed wait count: only the bench timeout ends a wait that never completes
    do begin
      @(posedge ref_clk);
    end while (waitrequest !== 1'h0);
    rd = readdata;
    read <= 1'h0;
    write <= 1'h0;
    // A released request stays down for one edge before the next
    @(posedge ref_clk);
  endtask

  // Read a register and compare it
  task automatic rdc(input string name, input logic [4:0] a, input logic [31:0] exp);
    bus(1'h0, a, 32'h0, 4'h1);
    check(name, exp, rd);
  endtask

  // Words change only while reset is held, three edges before release
  task automatic boot(input boot_select_pkg::cfg_words_t w);
    int n = 0;
    rst_b <= 1'h0;
    cfg <= w;
    repeat (3) @(posedge ref_clk);
    rst_b <= 1'h1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (cfg_ready !== 1'h1 && n < 10);
    check("cfg_ready", 32'h1, 32'(cfg_ready));
    @(posedge ref_clk);
  endtask

  initial begin
    logic dual;
    logic prot;
    logic lock;
    logic [31:0] st;
    for (int i = 0; i < 9; i++) begin
      // The reserved code counts as single partition
      dual = (t_mode[i] == boot_select_pkg::MODE_DUAL) ||
             (t_mode[i] == boot_select_pkg::MODE_PROT_DUAL);
      prot = t_mode[i] == boot_select_pkg::MODE_PROT_DUAL;
      lock = prot && !t_act[i];
      boot({14'h3fff, t_mode[i], t_s0[i], t_s1[i]});
      check("dual_mode", 32'(dual), 32'(dual_mode));
      // Single partition always runs from partition 0
      check("active_part", 32'(dual ? t_act[i] : 1'h0), 32'(active_part));
      rdc("mode word", boot_select_pkg::MODE_CFG_OFFSET, {16'h0, 14'h3fff, t_mode[i]});
      rdc("seq0 word", boot_select_pkg::SEQ0_OFFSET, {8'h0, t_s0[i]});
      rdc("seq1 word", boot_select_pkg::SEQ1_OFFSET, {8'h0, t_s1[i]});
      // Active bit only has meaning in the dual modes
      st = {26'h0, t_val[i], prot, dual, t_act[i], 1'h1};
      bus(1'h0, boot_select_pkg::STATUS_OFFSET, 32'h0, 4'h1);
      check("status", st & (dual ? 32'h3f : 32'h3d), rd & (dual ? 32'h3f : 32'h3d));
      rdc("ctrl reset", boot_select_pkg::WR_CTRL_OFFSET, 32'h0);
      bus(1'h1, boot_select_pkg::WR_CTRL_OFFSET, 32'h3, 4'h1);
      @(posedge ref_clk);
      check("part0_wr_en", 32'h1, 32'(part0_wr_en));
      check("part1_wr_en", 32'(!lock), 32'(part1_wr_en));
      bus(1'h0, boot_select_pkg::STATUS_OFFSET, 32'h0, 4'h1);
      check("blocked", 32'(lock), 32'(rd[6]));
      if (lock) begin
        bus(1'h1, boot_select_pkg::STATUS_OFFSET, 32'h40, 4'h1);
        bus(1'h0, boot_select_pkg::STATUS_OFFSET, 32'h0, 4'h1);
        check("blocked cleared", 32'h0, 32'(rd[6]));
      end
      if (i == 0) begin
        // Program-once words ignore bus writes; unmapped reads give zero, lane-less writes are ignored
        bus(1'h1, boot_select_pkg::MODE_CFG_OFFSET, 32'h0, 4'h1);
        rdc("mode after write", boot_select_pkg::MODE_CFG_OFFSET, 32'hffff);
        rdc("unmapped", 5'h14, 32'h0);
        bus(1'h1, boot_select_pkg::WR_CTRL_OFFSET, 32'h0, 4'h0);
        rdc("ctrl lane off", boot_select_pkg::WR_CTRL_OFFSET, 32'h3);
      end
      $display("Test case %0d done", i);
    end
    give_verdict();
  end
endmodule
